// >>> common/lane_cfg_params.svh
// Register offsets, field positions, reset values and timing counts of the lane bank.
// Assumes a single 200 MHz clock and byte-wide registers on the management port.
`ifndef LANE_CFG_PARAMS_SVH
`define LANE_CFG_PARAMS_SVH

`define ADDR_B2_DEEMPH_STATUS   8'h1F
`define ADDR_B2_IDLE_THRESHOLD  8'h20
`define ADDR_B3_IDLE_DETECT     8'h23
`define ADDR_B3_EQUALIZER       8'h24
`define ADDR_B3_SWING_MODE      8'h25
`define ADDR_B3_DEEMPH_STATUS   8'h26
`define ADDR_B3_IDLE_THRESHOLD  8'h27

`define RST_DEEMPH_STATUS       8'h02
`define RST_IDLE_THRESHOLD      8'h00
`define RST_IDLE_DETECT         8'h00
`define RST_EQUALIZER           8'h2F
`define RST_SWING_MODE          8'hAD

`define BIT_RECEIVER_FOUND      7
`define BIT_RATE_HI             6
`define BIT_RATE_LO             5
`define BIT_IDLE_AUTO           5
`define BIT_IDLE_FORCE          4
`define BIT_PRESENCE_HI         3
`define BIT_PRESENCE_LO         2
`define BIT_DEASSERT_HI         3
`define BIT_DEASSERT_LO         2
`define BIT_ASSERT_HI           1
`define BIT_ASSERT_LO           0
`define BIT_SHORT_PROTECT       7
`define BIT_RATE_SELECT         6
`define BIT_SWING_HI            2
`define BIT_SWING_LO            0
`define BIT_DEEMPH_HI           2
`define BIT_DEEMPH_LO           0

`define PRESENCE_HIZ            2'h0
`define PRESENCE_AUTO_LIMITED   2'h1
`define PRESENCE_AUTO_ENDLESS   2'h2
`define PRESENCE_FIXED_50       2'h3

`define CLK_MHZ                 200
`define DETECT_INTERVAL_MS      12
`define DETECT_INTERVAL_CYCLES  (`DETECT_INTERVAL_MS * 1000 * `CLK_MHZ)
`define DETECT_MAX_ATTEMPTS     50
`define SWING_BASE_MV           700
`define SWING_STEP_MV           100

`endif

// >>> common/lane_cfg_pkg.sv
// Types shared by the lane configuration bank and its presence-detect sequencer.
// Assumes the constants of lane_cfg_params.svh for the field encodings.
package lane_cfg_pkg;

    typedef logic [1:0] presence_code_t;
    typedef logic [1:0] rate_code_t;
    typedef logic [7:0] reg_byte_t;

    typedef enum logic [2:0] {
        DET_OFF,
        DET_WAIT,
        DET_SAMPLE,
        DET_FOUND,
        DET_STOPPED
    } detect_state_t;

endpackage

// >>> hdl/presence_detect_seq.sv
// Receiver presence-detect sequencer for one lane.
// Assumes probe_result is valid in the same cycle as the probe pulse.
`timescale 1ns/1ps
`include "lane_cfg_params.svh"

module presence_detect_seq #(
    parameter int INTERVAL_CYCLES = `DETECT_INTERVAL_CYCLES,
    parameter int MAX_ATTEMPTS    = `DETECT_MAX_ATTEMPTS
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire lane_cfg_pkg::presence_code_t mode,
    input  wire logic                        probe_result,
    output logic                             probe,
    output logic                             found,
    output logic                             term_50ohm,
    output logic                             stopped
);
    import lane_cfg_pkg::*;

    detect_state_t  state;
    presence_code_t last_mode;
    logic [31:0]    interval_cnt;
    logic [7:0]     attempts;
    logic           auto_mode;

    always_comb begin
        auto_mode = (mode == `PRESENCE_AUTO_LIMITED) || (mode == `PRESENCE_AUTO_ENDLESS);
    end

    // A change of mode restarts the sequence from scratch.
    always_ff @(posedge clk) begin
        if (srst) begin
            state        <= DET_OFF;
            last_mode    <= `PRESENCE_HIZ;
            interval_cnt <= 32'h0;
            attempts     <= 8'h0;
            probe        <= 1'b0;
            found        <= 1'b0;
            stopped      <= 1'b0;
        end else begin
            last_mode <= mode;
            probe     <= 1'b0;
            if (mode != last_mode || !auto_mode) begin
                state        <= auto_mode ? DET_WAIT : DET_OFF;
                interval_cnt <= 32'h0;
                attempts     <= 8'h0;
                found        <= 1'b0;
                stopped      <= 1'b0;
            end else begin
                case (state)
                    DET_WAIT: begin
                        if (interval_cnt == 32'(INTERVAL_CYCLES - 1)) begin
                            interval_cnt <= 32'h0;
                            probe        <= 1'b1;
                            attempts     <= attempts + 8'h1;
                            state        <= DET_SAMPLE;
                        end else begin
                            interval_cnt <= interval_cnt + 32'h1;
                        end
                    end
                    DET_SAMPLE: begin
                        interval_cnt <= interval_cnt + 32'h1;
                        if (probe_result) begin
                            found <= 1'b1;
                            state <= DET_FOUND;
                        end else if (mode == `PRESENCE_AUTO_LIMITED &&
                                     attempts == 8'(MAX_ATTEMPTS)) begin
                            stopped <= 1'b1;
                            state   <= DET_STOPPED;
                        end else begin
                            state <= DET_WAIT;
                        end
                    end
                    DET_OFF, DET_FOUND, DET_STOPPED: begin
                        state <= state;
                    end
                    default: begin
                        state <= DET_OFF;
                    end
                endcase
            end
        end
    end

    // Termination: fixed code gives 50 ohm, auto codes only after detection.
    always_ff @(posedge clk) begin
        if (srst) begin
            term_50ohm <= 1'b0;
        end else if (mode == `PRESENCE_FIXED_50) begin
            term_50ohm <= 1'b1;
        end else if (auto_mode && mode == last_mode) begin
            term_50ohm <= found || (state == DET_SAMPLE && probe_result);
        end else begin
            term_50ohm <= 1'b0;
        end
    end

endmodule // presence_detect_seq

// >>> hdl/lane_config_register_bank.sv
// Configuration and observation registers for lane b3 and the tail of lane b2.
// Assumes a byte-wide management port already decoded from the serial bus.
//
// What this block does
// - Code 00 high impedance, 11 fixed 50 ohm.
// - Code 01 probes every 12 ms, 50 tries.
// - Code 10 probes every 12 ms until found.
// - Auto modes: high impedance until found, then 50.
// - Register presence field overrides presence strap.
// - Forced idle honoured only without auto idle.
// - Bit 5 selects automatic idle detection.
// - Forced idle bit one mutes the output.
// - Deassert threshold codes 110, 100, 150, 130.
// - Assert threshold codes 180, 160, 210, 190.
// - Register thresholds replace threshold strap pin.
// - Bit 6 one gen1/2, zero gen3.
// - Swing bit 7 enables short-circuit protection.
// - Swing code maps 0.7 V to 1.4 V.
// - De-emphasis code maps 0 to -12 dB.
// - Status bit 7 shows receiver found.
// - Status bits 6:5 report detected rate.
// - Equalizer boost eight bits, reset 0x2F.
`timescale 1ns/1ps
`include "lane_cfg_params.svh"

module lane_config_register_bank #(
    parameter int DETECT_INTERVAL_CYCLES = `DETECT_INTERVAL_CYCLES,
    parameter int DETECT_MAX_ATTEMPTS    = `DETECT_MAX_ATTEMPTS
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    // Management port.
    input  wire logic [7:0]                  reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_rd,
    output logic [7:0]                       reg_rdata,
    // Strap pins.
    input  wire lane_cfg_pkg::presence_code_t presence_strap,
    input  wire logic                        signal_detect_threshold_pin,
    input  wire logic                        rate_mode_pin,
    // Live state from the analog lanes.
    input  wire logic                        b3_probe_result,
    input  wire lane_cfg_pkg::rate_code_t    b3_detected_rate,
    input  wire logic                        b2_receiver_found,
    input  wire lane_cfg_pkg::rate_code_t    b2_detected_rate,
    // Lane b3 controls.
    output logic                             b3_probe,
    output logic                             b3_term_50ohm,
    output logic                             b3_detect_stopped,
    output logic                             b3_idle_auto,
    output logic                             b3_mute,
    output logic                             b3_threshold_from_reg,
    output logic [7:0]                       b3_deassert_mv,
    output logic [7:0]                       b3_assert_mv,
    output logic                             b3_rate_gen12,
    output logic                             b3_short_protect,
    output logic [10:0]                      b3_swing_mv,
    output logic [2:0]                       b3_deemph_code,
    output logic [7:0]                       b3_equalizer_boost,
    // Lane b2 tail controls.
    output logic                             b2_threshold_from_reg,
    output logic [7:0]                       b2_deassert_mv,
    output logic [7:0]                       b2_assert_mv,
    output logic [2:0]                       b2_deemph_code
);
    import lane_cfg_pkg::*;

    reg_byte_t      lane_b2_deemph_status;
    reg_byte_t      lane_b2_idle_threshold;
    reg_byte_t      lane_b3_idle_detect_ctrl;
    reg_byte_t      lane_b3_equalizer;
    reg_byte_t      lane_b3_swing_mode;
    reg_byte_t      lane_b3_deemph_status;
    reg_byte_t      lane_b3_idle_threshold;

    logic           presence_written;
    logic           b2_threshold_written;
    logic           b3_threshold_written;
    logic           swing_written;

    logic           b3_found;
    logic           b2_found_live;
    rate_code_t     b3_rate_live;
    rate_code_t     b2_rate_live;
    presence_code_t next_presence_mode;
    presence_code_t presence_mode;

    function automatic logic wr_hit(input logic [7:0] addr);
        return reg_wr && (reg_addr == addr);
    endfunction

    // Idle de-assert threshold in mVp-p.
    function automatic logic [7:0] deassert_mv(input logic [1:0] code);
        case (code)
            2'h0:    return 8'h6E;
            2'h1:    return 8'h64;
            2'h2:    return 8'h96;
            default: return 8'h82;
        endcase
    endfunction

    // Idle assert threshold in mVp-p.
    function automatic logic [7:0] assert_mv(input logic [1:0] code);
        case (code)
            2'h0:    return 8'hB4;
            2'h1:    return 8'hA0;
            2'h2:    return 8'hD2;
            default: return 8'hBE;
        endcase
    endfunction

    // Observation byte: live status in 7:5, stored control bits below.
    function automatic reg_byte_t status_view(input reg_byte_t stored, input logic found_bit,
                                              input rate_code_t rate);
        return {found_bit, rate, stored[4:0]};
    endfunction

    // Writable bytes of lane b2.
    always_ff @(posedge clk) begin
        if (srst) begin
            lane_b2_deemph_status  <= `RST_DEEMPH_STATUS;
            lane_b2_idle_threshold <= `RST_IDLE_THRESHOLD;
        end else begin
            // Status bits 7:5 are not stored, so writes to them are dropped.
            if (wr_hit(`ADDR_B2_DEEMPH_STATUS)) begin
                lane_b2_deemph_status <= {3'h0, reg_wdata[4:0]};
            end
            if (wr_hit(`ADDR_B2_IDLE_THRESHOLD)) begin
                lane_b2_idle_threshold <= reg_wdata;
            end
        end
    end

    // Writable bytes of lane b3.
    always_ff @(posedge clk) begin
        if (srst) begin
            lane_b3_idle_detect_ctrl <= `RST_IDLE_DETECT;
            lane_b3_equalizer        <= `RST_EQUALIZER;
            lane_b3_swing_mode       <= `RST_SWING_MODE;
            lane_b3_deemph_status    <= `RST_DEEMPH_STATUS;
            lane_b3_idle_threshold   <= `RST_IDLE_THRESHOLD;
        end else begin
            if (wr_hit(`ADDR_B3_IDLE_DETECT)) begin
                lane_b3_idle_detect_ctrl <= reg_wdata;
            end
            if (wr_hit(`ADDR_B3_EQUALIZER)) begin
                lane_b3_equalizer <= reg_wdata;
            end
            // Reserved bits 5:3 are stored as written; software keeps them at 101.
            if (wr_hit(`ADDR_B3_SWING_MODE)) begin
                lane_b3_swing_mode <= reg_wdata;
            end
            if (wr_hit(`ADDR_B3_DEEMPH_STATUS)) begin
                lane_b3_deemph_status <= {3'h0, reg_wdata[4:0]};
            end
            if (wr_hit(`ADDR_B3_IDLE_THRESHOLD)) begin
                lane_b3_idle_threshold <= reg_wdata;
            end
        end
    end

    // A strap governs only until software first writes the matching register.
    always_ff @(posedge clk) begin
        if (srst) begin
            presence_written     <= 1'b0;
            b2_threshold_written <= 1'b0;
            b3_threshold_written <= 1'b0;
            swing_written        <= 1'b0;
        end else begin
            if (wr_hit(`ADDR_B3_IDLE_DETECT)) begin
                presence_written <= 1'b1;
            end
            if (wr_hit(`ADDR_B2_IDLE_THRESHOLD)) begin
                b2_threshold_written <= 1'b1;
            end
            if (wr_hit(`ADDR_B3_IDLE_THRESHOLD)) begin
                b3_threshold_written <= 1'b1;
            end
            if (wr_hit(`ADDR_B3_SWING_MODE)) begin
                swing_written <= 1'b1;
            end
        end
    end

    // Once software has written the byte, its code wins over the strap level.
    always_comb begin
        if (presence_written) begin
            next_presence_mode = lane_b3_idle_detect_ctrl[`BIT_PRESENCE_HI:`BIT_PRESENCE_LO];
        end else begin
            next_presence_mode = presence_strap;
        end
    end

    // One register stage, so the sequencer sees each mode change on a clean edge.
    always_ff @(posedge clk) begin
        if (srst) begin
            presence_mode <= `PRESENCE_HIZ;
        end else begin
            presence_mode <= next_presence_mode;
        end
    end

    presence_detect_seq #(
        .INTERVAL_CYCLES (DETECT_INTERVAL_CYCLES),
        .MAX_ATTEMPTS    (DETECT_MAX_ATTEMPTS)
    ) u_b3_detect (
        .clk          (clk),
        .srst         (srst),
        .mode         (presence_mode),
        .probe_result (b3_probe_result),
        .probe        (b3_probe),
        .found        (b3_found),
        .term_50ohm   (b3_term_50ohm),
        .stopped      (b3_detect_stopped)
    );

    // Live detection state, independent of register writes.
    always_ff @(posedge clk) begin
        if (srst) begin
            b2_found_live <= 1'b0;
            b2_rate_live  <= 2'h0;
            b3_rate_live  <= 2'h0;
        end else begin
            b2_found_live <= b2_receiver_found;
            b2_rate_live  <= b2_detected_rate;
            b3_rate_live  <= b3_detected_rate;
        end
    end

    // Idle control of lane b3.
    always_ff @(posedge clk) begin
        if (srst) begin
            b3_idle_auto <= 1'b0;
            b3_mute      <= 1'b0;
        end else begin
            b3_idle_auto <= lane_b3_idle_detect_ctrl[`BIT_IDLE_AUTO];
            b3_mute      <= !lane_b3_idle_detect_ctrl[`BIT_IDLE_AUTO] &&
                            lane_b3_idle_detect_ctrl[`BIT_IDLE_FORCE];
        end
    end

    // Idle thresholds of lane b3; before a write the strap pin's setting stays in force.
    always_ff @(posedge clk) begin
        if (srst) begin
            b3_threshold_from_reg <= 1'b0;
            b3_deassert_mv        <= 8'h6E;
            b3_assert_mv          <= 8'hB4;
        end else begin
            b3_threshold_from_reg <= b3_threshold_written;
            b3_deassert_mv <= deassert_mv(
                lane_b3_idle_threshold[`BIT_DEASSERT_HI:`BIT_DEASSERT_LO]);
            b3_assert_mv   <= assert_mv(lane_b3_idle_threshold[`BIT_ASSERT_HI:`BIT_ASSERT_LO]);
        end
    end

    // Idle thresholds of lane b2, handled the same way.
    always_ff @(posedge clk) begin
        if (srst) begin
            b2_threshold_from_reg <= 1'b0;
            b2_deassert_mv        <= 8'h6E;
            b2_assert_mv          <= 8'hB4;
        end else begin
            b2_threshold_from_reg <= b2_threshold_written;
            b2_deassert_mv <= deassert_mv(
                lane_b2_idle_threshold[`BIT_DEASSERT_HI:`BIT_DEASSERT_LO]);
            b2_assert_mv   <= assert_mv(lane_b2_idle_threshold[`BIT_ASSERT_HI:`BIT_ASSERT_LO]);
        end
    end

    // Rate mode, protection and swing of lane b3.
    always_ff @(posedge clk) begin
        if (srst) begin
            b3_rate_gen12    <= 1'b0;
            b3_short_protect <= 1'b1;
            b3_swing_mv      <= 11'h4B0;
        end else begin
            b3_rate_gen12    <= swing_written ? lane_b3_swing_mode[`BIT_RATE_SELECT]
                                              : rate_mode_pin;
            b3_short_protect <= lane_b3_swing_mode[`BIT_SHORT_PROTECT];
            b3_swing_mv      <= 11'(`SWING_BASE_MV + `SWING_STEP_MV *
                                32'(lane_b3_swing_mode[`BIT_SWING_HI:`BIT_SWING_LO]));
        end
    end

    // De-emphasis and equalizer levels of lane b3 pass straight to the analog lane.
    always_ff @(posedge clk) begin
        if (srst) begin
            b3_deemph_code     <= 3'h2;
            b3_equalizer_boost <= `RST_EQUALIZER;
        end else begin
            b3_deemph_code     <= lane_b3_deemph_status[`BIT_DEEMPH_HI:`BIT_DEEMPH_LO];
            b3_equalizer_boost <= lane_b3_equalizer;
        end
    end

    // De-emphasis level of lane b2.
    always_ff @(posedge clk) begin
        if (srst) begin
            b2_deemph_code <= 3'h2;
        end else begin
            b2_deemph_code <= lane_b2_deemph_status[`BIT_DEEMPH_HI:`BIT_DEEMPH_LO];
        end
    end

    // Read data is registered and holds until the next read; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_B2_DEEMPH_STATUS: begin
                    reg_rdata <= status_view(lane_b2_deemph_status, b2_found_live,
                                             b2_rate_live);
                end
                `ADDR_B2_IDLE_THRESHOLD: begin
                    reg_rdata <= lane_b2_idle_threshold;
                end
                `ADDR_B3_IDLE_DETECT: begin
                    reg_rdata <= lane_b3_idle_detect_ctrl;
                end
                `ADDR_B3_EQUALIZER: begin
                    reg_rdata <= lane_b3_equalizer;
                end
                `ADDR_B3_SWING_MODE: begin
                    reg_rdata <= lane_b3_swing_mode;
                end
                `ADDR_B3_DEEMPH_STATUS: begin
                    reg_rdata <= status_view(lane_b3_deemph_status, b3_found,
                                             b3_rate_live);
                end
                `ADDR_B3_IDLE_THRESHOLD: begin
                    reg_rdata <= lane_b3_idle_threshold;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

endmodule // lane_config_register_bank

// >>> testbench/lane_cfg_properties.sv
// Concurrent checks on the ports of the lane configuration bank.
// Assumes one clock, a synchronous active-high reset and a short detect interval.
`timescale 1ns/1ps
module lane_cfg_checker #(
    parameter int DETECT_INTERVAL_CYCLES = 8
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        b3_probe_result,
    input wire logic        b3_probe,
    input wire logic        b3_term_50ohm,
    input wire logic        b3_detect_stopped,
    input wire logic        b3_idle_auto,
    input wire logic        b3_mute,
    input wire logic        b3_rate_gen12,
    input wire logic        b3_short_protect,
    input wire logic [10:0] b3_swing_mv,
    input wire logic [2:0]  b3_deemph_code,
    input wire logic [7:0]  b3_equalizer_boost
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    int gap;
    // Cycles since the last probe; one interval apart leaves it at one less than the interval.
    always_ff @(posedge clk) begin
        gap <= (srst || b3_probe) ? 0 : gap + 1;
    end
    property idle_p;
        logic [7:0] v;
        (reg_wr && reg_addr == 8'h23, v = reg_wdata) |->
            ##2 (b3_idle_auto == v[5] && b3_mute == (!v[5] && v[4]));
    endproperty
    property swing_p;
        logic [7:0] v;
        (reg_wr && reg_addr == 8'h25, v = reg_wdata) |-> ##2 (b3_short_protect == v[7] &&
            b3_rate_gen12 == v[6] && b3_swing_mv == 11'h2BC + 11'h064 * v[2:0]);
    endproperty
    mute_manual_a: assert property (b3_mute |-> !b3_idle_auto)
        else $error("mute while auto idle");
    idle_ctrl_a: assert property (idle_p)
        else $error("idle controls wrong");
    swing_fields_a: assert property (swing_p)
        else $error("swing fields wrong");
    eq_boost_a: assert property (reg_wr && reg_addr == 8'h24 |-> ##2
        b3_equalizer_boost == $past(reg_wdata, 2)) else $error("boost wrong");
    deemph_code_a: assert property (reg_wr && reg_addr == 8'h26 |-> ##2
        b3_deemph_code == 3'($past(reg_wdata, 2))) else $error("deemph wrong");
    probe_spacing_a: assert property (b3_probe |-> gap >= DETECT_INTERVAL_CYCLES - 1)
        else $error("probes too close");
    hit_term_a: assert property (b3_probe && b3_probe_result |=> b3_term_50ohm)
        else $error("no termination after hit");
    stop_quiet_a: assert property (b3_detect_stopped |-> !b3_probe && !b3_term_50ohm)
        else $error("activity after stop");
    cover property (b3_probe && b3_probe_result);
    cover property (b3_detect_stopped);
    cover property (b3_mute);
endmodule // lane_cfg_checker

bind lane_config_register_bank lane_cfg_checker #(
    .DETECT_INTERVAL_CYCLES(DETECT_INTERVAL_CYCLES)
) i_lane_cfg_checker (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .b3_probe_result(b3_probe_result), .b3_probe(b3_probe), .b3_term_50ohm(b3_term_50ohm),
    .b3_detect_stopped(b3_detect_stopped), .b3_idle_auto(b3_idle_auto), .b3_mute(b3_mute),
    .b3_rate_gen12(b3_rate_gen12), .b3_short_protect(b3_short_protect),
    .b3_swing_mv(b3_swing_mv), .b3_deemph_code(b3_deemph_code),
    .b3_equalizer_boost(b3_equalizer_boost)
);

// >>> testbench/tb_top.sv
// Self-checking bench for the lane configuration bank.
// Assumes the byte register port and a detect interval shortened to 8 cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, hit = 0, b3_probe_result = 0;
    logic b2_receiver_found = 0, rate_mode_pin = 1, signal_detect_threshold_pin = 0;
    logic b3_probe, b3_term_50ohm, b3_detect_stopped, b3_idle_auto, b3_mute, b3_rate_gen12;
    logic b3_short_protect, b3_threshold_from_reg, b2_threshold_from_reg;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, b3_deassert_mv, b3_assert_mv;
    logic [7:0] b2_deassert_mv, b2_assert_mv, b3_equalizer_boost;
    logic [1:0] presence_strap = 2'h3, b3_detected_rate = 0, b2_detected_rate = 0;
    logic [10:0] b3_swing_mv;
    logic [2:0] b3_deemph_code, b2_deemph_code;
    logic [7:0] adr[8] = '{8'h1F, 8'h20, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30};
    logic [7:0] rst[8] = '{8'h02, 8'h00, 8'h00, 8'h2F, 8'hAD, 8'h02, 8'h00, 8'h00};
    logic [7:0] deas[4] = '{8'h6E, 8'h64, 8'h96, 8'h82};
    logic [7:0] asrt[4] = '{8'hB4, 8'hA0, 8'hD2, 8'hBE};
    int num_errors = 0, n_compared = 0, probes = 0, i;
    lane_config_register_bank #(.DETECT_INTERVAL_CYCLES(8), .DETECT_MAX_ATTEMPTS(3))
        i_lane_config_register_bank (.*);
    always #2.5 clk = ~clk;
    // The far receiver answers in the same cycle as each probe, 1 ns after the edge.
    always @(posedge clk) begin
        #1 b3_probe_result = b3_probe & hit;
        if (b3_probe) probes++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk) #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(posedge clk) #1;
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk) #1;
        reg_addr = a;
        reg_rd = 1;
        @(posedge clk) #1;
        reg_rd = 0;
        `CHK("read data", ex, reg_rdata)
    endtask
    task automatic give_verdict;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 srst = 0;
        for (i = 0; i < 8; i++) rd(adr[i], rst[i]);
        `CHK("strap rate", 1'b1, b3_rate_gen12)
        `CHK("strap term", 1'b1, b3_term_50ohm)
        wr(8'h23, 8'h00);
        tick(3);
        `CHK("reg over strap", 1'b0, b3_term_50ohm)
        b2_receiver_found = 1;
        b2_detected_rate = 2'h1;
        b3_detected_rate = 2'h3;
        rd(8'h1F, 8'hA2);
        for (i = 0; i < 4; i++) begin
            wr(8'h27, 8'(i * 5));
            wr(8'h20, 8'(i * 5));
            tick(1);
            `CHK("deassert", {deas[i], deas[i]}, {b3_deassert_mv, b2_deassert_mv})
            `CHK("assert", {asrt[i], asrt[i]}, {b3_assert_mv, b2_assert_mv})
        end
        `CHK("thr source", 2'h3, {b3_threshold_from_reg, b2_threshold_from_reg})
        for (i = 0; i < 8; i++) begin
            wr(8'h25, {i[0], i[1], 3'h5, 3'(i)});
            tick(1);
            `CHK("swing", 11'h2BC + 11'h064 * 11'(i), b3_swing_mv)
            `CHK("rate protect", {i[1], i[0]}, {b3_rate_gen12, b3_short_protect})
            rd(8'h25, {i[0], i[1], 3'h5, 3'(i)});
            wr(8'h26, 8'(i | 8'hF8));
            tick(1);
            `CHK("deemph", 3'(i), b3_deemph_code)
        end
        rd(8'h26, 8'h7F);
        wr(8'h1F, 8'hFD);
        tick(1);
        `CHK("b2 deemph", 3'h5, b2_deemph_code)
        rd(8'h1F, 8'hBD);
        wr(8'h23, 8'h10);
        tick(1);
        `CHK("forced mute", 2'h1, {b3_idle_auto, b3_mute})
        wr(8'h23, 8'h30);
        tick(1);
        `CHK("auto idle", 2'h2, {b3_idle_auto, b3_mute})
        wr(8'h24, 8'h55);
        rd(8'h24, 8'h55);
        `CHK("boost", 8'h55, b3_equalizer_boost)
        probes = 0;
        wr(8'h23, 8'h04);
        for (i = 0; i < 100 && b3_detect_stopped !== 1'b1; i++) tick(1);
        tick(20);
        `CHK("limited probes", 4'h3, 4'(probes))
        probes = 0;
        wr(8'h23, 8'h08);
        for (i = 0; i < 100 && probes < 5; i++) tick(1);
        `CHK("endless", 2'h0, {b3_detect_stopped, b3_term_50ohm})
        hit = 1;
        for (i = 0; i < 30 && b3_term_50ohm !== 1'b1; i++) tick(1);
        `CHK("found term", 1'b1, b3_term_50ohm)
        rd(8'h26, 8'hFF);
        wr(8'h23, 8'h0C);
        probes = 0;
        tick(20);
        `CHK("fixed term", 5'h10, {b3_term_50ohm, 4'(probes)})
        rd(8'h26, 8'h7F);
        wr(8'h23, 8'h00);
        tick(3);
        `CHK("hiz term", 1'b0, b3_term_50ohm)
        give_verdict;
    end
endmodule // tb_top
